/* src/uepc_endpoint_ctrl.sv */
// Local design decisions: the address map and register access over AHB-Lite.
`timescale 1ns/1ns
module uepc_endpoint_ctrl
  import uepc_pkg::*;
#(
  parameter int unsigned IDLE_SLEEP_REQUEST_CYCLES = SUSPEND_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rst,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // Packet engine, same clock
  input  wire logic        tok_valid,
  input  wire logic [1:0]  tok_pid,
  input  wire logic [6:0]  tok_addr,
  input  wire logic [3:0]  tok_ep,
  input  wire logic        rx_done,
  input  wire logic        rx_ok,
  input  wire logic        rx_data1,
  input  wire logic [3:0]  rx_len,
  input  wire logic        host_ack,
  input  wire logic        host_timeout,
  input  wire logic        bus_reset,
  input  wire logic        sof_seen,
  input  wire logic        resume_done,
  // Transceiver pin, asynchronous
  input  wire logic        line_idle,
  // Answers to the engine
  output logic             hs_valid,
  output uepc_hs_t         hs_kind,
  output logic             tx_data1,
  output logic [3:0]       tx_len,
  output logic [15:0]      buf_addr,
  // Event flags and side controls
  output logic             ev_good,
  output logic             ev_sleep,
  output logic             ev_wake,
  output logic             ev_busrst,
  output logic             ev_sof,
  output logic             cpu_wake,
  output logic             pwr_down,
  output logic             resume_drive
);

  logic [7:0]  tx_q [NUM_EP];
  logic [7:0]  rx_q [NUM_EP];
  logic [7:0]  base_high_q;
  logic [1:0]  base_low_q;
  logic [1:0]  last_ep_q;
  logic [3:0]  rx_cnt_q;
  logic [6:0]  device_bus_address_q;
  logic [3:0]  ctrl_q;
  logic        fres_prev_q;
  logic        idle_s1_q;
  logic        idle_s2_q;
  logic [19:0] idle_cnt_q;
  uepc_state_t state_q;
  logic [1:0]  cur_ep_q;
  logic [1:0]  cur_pid_q;

  // Bus pipeline
  logic        wr_pend_q;
  logic        rd_pend_q;
  logic [7:0]  bus_idx_q;
  logic        addr_ok_q;

  // Combinational decisions
  logic        ep_clear;
  logic [NUM_EP-1:0] ep_hit;
  logic        tok_hit;
  logic [1:0]  tok_idx;
  logic        is_ctrl_ep;
  logic        ans_fire;
  uepc_hs_t    ans_kind;
  uepc_state_t state_d;
  logic        good_in;
  logic        good_rx;
  logic        tok_setup;
  logic [1:0]  st_tx;
  logic [1:0]  st_rx;
  logic        activity;
  logic [7:0]  rd_mux;
  logic [7:0]  wbyte;
  logic        bus_take;

  // Holding FRES keeps the endpoint side in reset, like a bus reset
  assign ep_clear = bus_reset | ctrl_q[CT_FRES];
  assign activity = ~idle_s2_q;
  assign wbyte    = hwdata[7:0];
  assign bus_take = hsel & htrans[1] & hready;

  // Endpoint 0 is fixed at number 0, others match their field
  genvar g;
  generate
    for (g = 0; g < NUM_EP; g++) begin : g_match
      if (g == 0) begin : g_zero
        assign ep_hit[g] = (tok_ep == 4'h0);
      end else begin : g_other
        assign ep_hit[g] = (tok_ep == rx_q[g][F_LOW_HI:0]); // RQ12
      end
    end
  endgenerate

  always_comb begin
    tok_idx = 2'd0;
    if (ep_hit[0]) begin
      tok_idx = 2'd0;
    end else if (ep_hit[1]) begin
      tok_idx = 2'd1;
    end else if (ep_hit[2]) begin
      tok_idx = 2'd2;
    end
  end

  assign tok_hit = tok_valid & (state_q == ST_IDLE) & ~ep_clear &
                   (tok_addr == device_bus_address_q) & (|ep_hit);
  assign is_ctrl_ep = (tok_idx == 2'd0) | rx_q[tok_idx][F_CTRL]; // RQ7
  assign tok_setup  = tok_hit & (tok_pid == TOK_SETUP) & is_ctrl_ep;
  assign st_tx = tx_q[cur_ep_q][F_STAT_HI:F_STAT_LO];
  assign st_rx = rx_q[cur_ep_q][F_STAT_HI:F_STAT_LO];

  always_comb begin
    ans_fire = 1'b0;
    ans_kind = HS_NONE;
    state_d  = state_q;
    good_in  = 1'b0;
    good_rx  = 1'b0;
    if (ep_clear) begin
      state_d = ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (tok_hit && tok_pid == TOK_IN) begin
            ans_fire = 1'b1;
            case (tx_q[tok_idx][F_STAT_HI:F_STAT_LO]) // RQ4
              STAT_DIS:   ans_kind = HS_NONE;
              STAT_STALL: ans_kind = HS_STALL;
              STAT_NAK:   ans_kind = HS_NAK;
              default: begin
                if (ev_good) begin
                  ans_kind = HS_NAK; // RQ24
                end else begin
                  ans_kind = HS_DATA;
                  state_d  = ST_WAIT_ACK;
                end
              end
            endcase
          end else if (tok_hit && tok_pid == TOK_OUT) begin
            state_d = ST_WAIT_RX;
          end else if (tok_setup) begin
            state_d = ST_WAIT_RX;
          end
        end
        ST_WAIT_RX: begin
          if (rx_done) begin
            state_d  = ST_IDLE;
            ans_fire = 1'b1;
            if (!rx_ok) begin
              ans_kind = HS_NONE; // RQ23
            end else begin
              case (st_rx) // RQ10
                STAT_DIS:   ans_kind = HS_NONE;
                STAT_STALL: ans_kind = HS_STALL;
                STAT_NAK:   ans_kind = HS_NAK;
                default: begin
                  if (ev_good) begin
                    ans_kind = HS_NAK; // RQ24
                  end else if (cur_pid_q == TOK_OUT &&
                               tx_q[cur_ep_q][F_STATUS_OUT_EXPECTED] &&
                               rx_len != 4'h0) begin
                    ans_kind = HS_STALL; // RQ1
                  end else begin
                    ans_kind = HS_ACK;
                    good_rx  = (rx_data1 == rx_q[cur_ep_q][F_TOG]); // RQ23
                  end
                end
              endcase
            end
          end
        end
        ST_WAIT_ACK: begin
          if (host_ack) begin
            good_in = 1'b1;
            state_d = ST_IDLE;
          end else if (host_timeout) begin
            state_d = ST_IDLE;
          end
        end
        default: state_d = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q   <= ST_IDLE;
      cur_ep_q  <= 2'd0;
      cur_pid_q <= TOK_OUT;
    end else begin
      state_q <= state_d;
      if (tok_hit) begin
        cur_ep_q  <= tok_idx;
        cur_pid_q <= tok_pid;
      end
    end
  end

  // Answer toward the engine; buffer slots sit on 000 boundaries
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hs_valid <= 1'b0;
      hs_kind  <= HS_NONE;
      tx_data1 <= 1'b0;
      tx_len   <= 4'h0;
      buf_addr <= 16'h0000;
    end else begin
      hs_valid <= ans_fire;
      if (ans_fire) begin
        hs_kind  <= ans_kind;
        tx_data1 <= tx_q[tok_idx][F_TOG]; // RQ2
        tx_len   <= tx_q[tok_idx][F_LOW_HI:0];
      end
      if (tok_hit) begin
        buf_addr <= {base_high_q, base_low_q, 6'h00} +
                    16'(tok_idx * BUF_SLOT_BYTES); // RQ15 RQ16
      end
    end
  end

  // Endpoint registers: bus reset or FRES wins over everything; other hardware
  // updates go first, and a software write in the same cycle overrides them
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NUM_EP; i++) begin
        tx_q[i] <= EP_TX_RST;
        rx_q[i] <= (i == 0) ? EP0_RX_RST : EP_RX_RST; // RQ13
      end
    end else if (ep_clear) begin
      for (int i = 0; i < NUM_EP; i++) begin
        tx_q[i] <= EP_TX_RST; // RQ18
        rx_q[i] <= (i == 0) ? EP0_RX_RST : EP_RX_RST; // RQ14 RQ18
      end
    end else begin
      if (tok_setup) begin
        tx_q[tok_idx][F_TOG] <= 1'b1; // RQ2
        rx_q[tok_idx][F_TOG] <= 1'b0; // RQ8
      end
      if (good_in) begin
        tx_q[cur_ep_q][F_TOG] <= ~tx_q[cur_ep_q][F_TOG]; // RQ3
        tx_q[cur_ep_q][F_STAT_HI:F_STAT_LO] <= STAT_NAK; // RQ5
      end
      if (good_rx) begin
        rx_q[cur_ep_q][F_TOG] <= ~rx_q[cur_ep_q][F_TOG]; // RQ9
        rx_q[cur_ep_q][F_STAT_HI:F_STAT_LO] <= STAT_NAK; // RQ11
        if (cur_pid_q == TOK_SETUP) begin
          tx_q[cur_ep_q][F_STAT_HI:F_STAT_LO] <= STAT_NAK; // RQ5
        end
      end
      if (wr_pend_q && addr_ok_q) begin
        for (int i = 0; i < NUM_EP; i++) begin
          if (bus_idx_q == IDX_EP0_TX + 8'(2 * i)) begin
            tx_q[i] <= wbyte; // RQ3
          end else if (bus_idx_q == IDX_EP0_RX + 8'(2 * i)) begin
            rx_q[i] <= (i == 0) ? ((wbyte & EP0_RX_KEEP) | EP0_RX_ONES)
                                : wbyte; // RQ13
          end
        end
      end
    end
  end

  // Device address, buffer base and last transfer info
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      device_bus_address_q     <= 7'h00;
      base_high_q <= 8'h00;
      base_low_q  <= 2'b00;
      last_ep_q   <= 2'd0;
      rx_cnt_q    <= 4'h0;
    end else begin
      if (ep_clear) begin
        device_bus_address_q <= 7'h00; // RQ18
      end else if (wr_pend_q && addr_ok_q && bus_idx_q == IDX_DEV_ADDR) begin
        device_bus_address_q <= wbyte[6:0];
      end
      if (wr_pend_q && addr_ok_q && bus_idx_q == IDX_BASE_HIGH) begin
        base_high_q <= wbyte; // RQ15
      end
      if (wr_pend_q && addr_ok_q && bus_idx_q == IDX_BASE_LOW) begin
        base_low_q <= wbyte[7:6]; // RQ15
      end
      // Frozen while the good-transfer flag stands
      if ((good_in || good_rx) && !ev_good) begin
        last_ep_q <= cur_ep_q;
        rx_cnt_q  <= good_rx ? rx_len : 4'h0;
      end
    end
  end

  // Control register; hardware drops forced suspend on activity
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_q      <= CTRL_RST;
      fres_prev_q <= 1'b0;
    end else begin
      fres_prev_q <= ctrl_q[CT_FRES];
      if (wr_pend_q && addr_ok_q && bus_idx_q == IDX_CTRL) begin
        ctrl_q <= wbyte[3:0];
      end else if (ctrl_q[CT_FSUSP] && activity) begin
        ctrl_q[CT_FSUSP] <= 1'b0; // RQ22
      end
    end
  end

  // Only the second stage is read by logic
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      idle_s1_q <= 1'b1;
      idle_s2_q <= 1'b1;
    end else begin
      idle_s1_q <= line_idle;
      idle_s2_q <= idle_s1_q;
    end
  end

  // Idle timer saturates so the request fires once per idle spell
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      idle_cnt_q <= 20'h00000;
    end else if (ep_clear || activity || ctrl_q[CT_FSUSP]) begin
      idle_cnt_q <= 20'h00000;
    end else if (idle_cnt_q != 20'(IDLE_SLEEP_REQUEST_CYCLES)) begin
      idle_cnt_q <= idle_cnt_q + 20'h00001; // RQ20
    end
  end

  // Sticky events: a write of 0 clears a bit, a new event wins
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ev_good   <= 1'b0;
      ev_sleep  <= 1'b0;
      ev_wake   <= 1'b0;
      ev_busrst <= 1'b0;
      ev_sof    <= 1'b0;
    end else begin
      if (wr_pend_q && addr_ok_q && bus_idx_q == IDX_EVENTS) begin
        ev_good   <= ev_good & wbyte[EV_GOOD];
        ev_sleep  <= ev_sleep & wbyte[EV_SLEEP];
        ev_wake   <= ev_wake & wbyte[EV_WAKE];
        ev_busrst <= ev_busrst & wbyte[EV_BUSRST];
        ev_sof    <= ev_sof & wbyte[EV_SOF];
      end
      if (good_in || good_rx) begin
        ev_good <= 1'b1; // RQ23
      end
      if (idle_cnt_q == 20'(IDLE_SLEEP_REQUEST_CYCLES - 1) && idle_s2_q &&
          !ctrl_q[CT_FSUSP] && !ep_clear) begin
        ev_sleep <= 1'b1; // RQ20
      end
      if (ctrl_q[CT_FSUSP] && activity) begin
        ev_wake <= 1'b1; // RQ22
      end
      if (bus_reset || (fres_prev_q && !ctrl_q[CT_FRES])) begin
        ev_busrst <= 1'b1;
      end
      if (sof_seen || resume_done) begin
        ev_sof <= 1'b1; // RQ21
      end
    end
  end

  // Stop-state release follows the wake flag
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cpu_wake     <= 1'b0;
      pwr_down     <= 1'b1;
      resume_drive <= 1'b0;
    end else begin
      cpu_wake     <= ev_wake; // RQ22
      pwr_down     <= ctrl_q[CT_PDWN];
      resume_drive <= ctrl_q[CT_RESUME];
    end
  end

  always_comb begin
    rd_mux = 8'h00;
    if (bus_idx_q == IDX_BASE_HIGH) begin
      rd_mux = base_high_q;
    end else if (bus_idx_q == IDX_BASE_LOW) begin
      rd_mux = {base_low_q, last_ep_q, rx_cnt_q};
    end else if (bus_idx_q == IDX_EVENTS) begin
      rd_mux = {ev_sleep, 1'b0, ev_good, 2'b00, ev_wake, ev_busrst, ev_sof};
    end else if (bus_idx_q == IDX_CTRL) begin
      rd_mux = {4'h0, ctrl_q};
    end else if (bus_idx_q == IDX_DEV_ADDR) begin
      rd_mux = {1'b0, device_bus_address_q};
    end else begin
      for (int i = 0; i < NUM_EP; i++) begin
        if (bus_idx_q == IDX_EP0_TX + 8'(2 * i)) begin
          rd_mux = tx_q[i];
        end else if (bus_idx_q == IDX_EP0_RX + 8'(2 * i)) begin
          rd_mux = rx_q[i];
        end
      end
    end
  end

  // Reads add one wait state so a write just before is visible
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      bus_idx_q <= 8'h00;
      addr_ok_q <= 1'b0;
      hreadyout <= 1'b1;
      hrdata    <= 32'h00000000;
      hresp     <= 1'b0;
    end else begin
      hresp <= 1'b0;
      if (rd_pend_q) begin
        rd_pend_q <= 1'b0;
        hreadyout <= 1'b1;
        hrdata    <= addr_ok_q ? {24'h000000, rd_mux} : 32'h00000000;
      end else begin
        wr_pend_q <= bus_take & hwrite;
        if (bus_take) begin
          bus_idx_q <= haddr[9:2];
          addr_ok_q <= (haddr[31:10] == 22'h000000) &&
                       (haddr[1:0] == 2'b00);
        end
        if (bus_take && !hwrite) begin
          rd_pend_q <= 1'b1;
          hreadyout <= 1'b0;
        end
      end
    end
  end

endmodule

/* pkg/uepc_pkg.sv */
// What this block does
// RQ1: status_out_expected stalls nonzero OUT data
// RQ2: tx_toggle picks DATA0/DATA1; SETUP sets it
// RQ3: tx_toggle flips on host ACK; software overrides
// RQ4: Transmit status: disabled, stall, nak, valid
// RQ5: Good IN or SETUP sets transmit NAK
// RQ6: Software loads buffer, then tx_byte_count
// RQ7: Control flag or endpoint 0 means control
// RQ8: rx_toggle expects DATA0/DATA1; SETUP clears it
// RQ9: rx_toggle flips only on matching good data
// RQ10: Receive status: disabled, stall, nak, valid
// RQ11: Good OUT or SETUP sets receive NAK
// RQ12: Endpoints 1, 2 match endpoint_number field
// RQ13: Endpoint zero receive register: bit7 one, resets 80h
// RQ14: Bus reset restores receive registers
// RQ15: Buffer base from buffer_base_bits, low bits zero
// RQ16: Buffers fill upward from 000 boundary
// RQ17: Software leaves enabled endpoint registers alone
// RQ18: Bus reset clears address, disables endpoints
// RQ19: Software re-enables endpoint 0 within 10 ms
// RQ20: Idle over 3 ms raises idle_sleep_request
// RQ21: Resume end also raises start-of-frame event
// RQ22: Activity in suspend raises wake, ends stop
// RQ23: Good transfer only without errors or NAK/STALL
// RQ24: While good_transfer_flag set, valid endpoints NAK
package uepc_pkg;

  localparam int NUM_EP        = 3;
  localparam int CLK_KHZ       = 100000;
  localparam int SUSPEND_MS    = 3;
  localparam int SUSPEND_CYCLES = SUSPEND_MS * CLK_KHZ;
  localparam int BUF_MAX_BYTES = 48;
  localparam int BUF_SLOT_BYTES = BUF_MAX_BYTES / NUM_EP;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_BASE_HIGH = 8'h26;
  localparam logic [7:0] IDX_BASE_LOW  = 8'h27;
  localparam logic [7:0] IDX_EVENTS    = 8'h28;
  localparam logic [7:0] IDX_CTRL      = 8'h2a;
  localparam logic [7:0] IDX_DEV_ADDR  = 8'h2b;
  localparam logic [7:0] IDX_EP0_TX    = 8'h2c;
  localparam logic [7:0] IDX_EP0_RX    = 8'h2d;

  // Endpoint register fields
  localparam int F_STATUS_OUT_EXPECTED  = 7;
  localparam int F_CTRL    = 7;
  localparam int F_TOG     = 6;
  localparam int F_STAT_HI = 5;
  localparam int F_STAT_LO = 4;
  localparam int F_LOW_HI  = 3;

  localparam logic [7:0] EP_TX_RST   = 8'h00;
  localparam logic [7:0] EP_RX_RST   = 8'h00;
  localparam logic [7:0] EP0_RX_RST  = 8'h80;
  localparam logic [7:0] EP0_RX_ONES = 8'h80;
  localparam logic [7:0] EP0_RX_KEEP = 8'h70;
  localparam logic [3:0] CTRL_RST    = 4'h6;

  // Event and control bit positions
  localparam int EV_SLEEP  = 7;
  localparam int EV_GOOD   = 5;
  localparam int EV_WAKE   = 2;
  localparam int EV_BUSRST = 1;
  localparam int EV_SOF    = 0;
  localparam int CT_RESUME = 3;
  localparam int CT_PDWN   = 2;
  localparam int CT_FSUSP  = 1;
  localparam int CT_FRES   = 0;

  localparam logic [1:0] STAT_DIS   = 2'b00;
  localparam logic [1:0] STAT_STALL = 2'b01;
  localparam logic [1:0] STAT_NAK   = 2'b10;
  localparam logic [1:0] STAT_VALID = 2'b11;

  localparam logic [1:0] TOK_OUT   = 2'b00;
  localparam logic [1:0] TOK_IN    = 2'b10;
  localparam logic [1:0] TOK_SETUP = 2'b11;

  typedef enum logic [2:0] {
    HS_NONE, HS_ACK, HS_NAK, HS_STALL, HS_DATA
  } uepc_hs_t;

  typedef enum logic [1:0] {
    ST_IDLE, ST_WAIT_RX, ST_WAIT_ACK
  } uepc_state_t;

endpackage

/* tb/uepc_monitor.sv */
`timescale 1ns/1ns
module uepc_monitor
  import uepc_pkg::*;
#(
  parameter int unsigned IDLE_SLEEP_REQUEST_CYCLES = SUSPEND_CYCLES
) (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        rx_done,
  input wire logic        rx_ok,
  input wire logic        host_ack,
  input wire logic        bus_reset,
  input wire logic        sof_seen,
  input wire logic        resume_done,
  input wire logic        line_idle,
  input wire logic        hs_valid,
  input wire uepc_hs_t    hs_kind,
  input wire logic [15:0] buf_addr,
  input wire logic        ev_good,
  input wire logic        ev_sleep,
  input wire logic        ev_wake,
  input wire logic        ev_busrst,
  input wire logic        ev_sof,
  input wire logic        cpu_wake
);
  logic [1:0]  idle_sync_q;
  logic [31:0] idle_cnt_q;

  // Own two-flop view of the pin, so the count never lags the design's
  always_ff @(posedge clk or posedge rst) begin
    if (rst) idle_sync_q <= 2'h0;
    else idle_sync_q <= {idle_sync_q[0], line_idle};
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) idle_cnt_q <= 32'h0;
    else if (!idle_sync_q[1]) idle_cnt_q <= 32'h0;
    else if (idle_cnt_q != 32'hffffffff) idle_cnt_q <= idle_cnt_q + 32'h1;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_okay; hresp == 1'b0; endproperty
  property p_wait_one; !hreadyout |=> hreadyout; endproperty
  property p_nak_busy;
    hs_valid && $past(ev_good) |-> hs_kind inside {HS_NONE, HS_NAK, HS_STALL};
  endproperty
  property p_good_cause;
    $rose(ev_good) |-> $past(host_ack || (rx_done && rx_ok));
  endproperty
  property p_bad_rx; rx_done && !rx_ok |=> !$rose(ev_good); endproperty
  property p_busrst; bus_reset |=> ev_busrst; endproperty
  property p_sof; sof_seen || resume_done |=> ev_sof; endproperty
  property p_wake; $rose(ev_wake) |=> cpu_wake; endproperty
  property p_sleep; $rose(ev_sleep) |-> idle_cnt_q >= IDLE_SLEEP_REQUEST_CYCLES - 1; endproperty
  property p_slot_low; hs_valid |-> buf_addr[3:0] == 4'h0; endproperty
  property p_slot_max; hs_valid |-> buf_addr[5:4] != 2'b11; endproperty

  a_okay: assert property (p_okay) else $error("hresp not OKAY");
  a_wait_one: assert property (p_wait_one) else $error("long wait state");
  a_nak_busy: assert property (p_nak_busy)
    else $error("answer not NAK while good flag set");
  a_good_cause: assert property (p_good_cause)
    else $error("good flag without cause");
  a_bad_rx: assert property (p_bad_rx)
    else $error("good flag after bad packet");
  a_busrst: assert property (p_busrst)
    else $error("bus reset flag missing");
  a_sof: assert property (p_sof) else $error("frame flag missing");
  a_wake: assert property (p_wake) else $error("cpu wake missing");
  a_sleep: assert property (p_sleep) else $error("early sleep");
  a_slot_low: assert property (p_slot_low) else $error("slot unaligned");
  a_slot_max: assert property (p_slot_max) else $error("slot past 48");

  c_data: cover property (hs_valid && hs_kind == HS_DATA);
  c_sleep: cover property ($rose(ev_sleep));
  c_wake: cover property ($rose(ev_wake));
endmodule

bind uepc_endpoint_ctrl uepc_monitor #(.IDLE_SLEEP_REQUEST_CYCLES(IDLE_SLEEP_REQUEST_CYCLES)) i_mon (.*);

/* tb/uepc_host_model.sv */
`timescale 1ns/1ns
module uepc_host_model
  import uepc_pkg::*;
(
  input  wire logic     clk,
  input  wire logic     hs_valid,
  input  wire uepc_hs_t hs_kind,
  output logic          tok_valid,
  output logic [1:0]    tok_pid,
  output logic [6:0]    tok_addr,
  output logic [3:0]    tok_ep,
  output logic          rx_done,
  output logic          rx_ok,
  output logic          rx_data1,
  output logic [3:0]    rx_len,
  output logic          host_ack,
  output logic          host_timeout,
  output logic          bus_reset,
  output logic          sof_seen,
  output logic          resume_done,
  output logic          line_idle
);
  initial begin
    {tok_valid, rx_done, host_ack, host_timeout} = 4'h0;
    {bus_reset, sof_seen, resume_done} = 3'h0;
    {tok_pid, tok_addr, tok_ep, rx_ok, rx_data1, rx_len} = 19'h0;
    line_idle = 1'b1;
  end

  // Qualifiers invert once the strobe drops, so stale values never match
  task automatic token(input logic [1:0] p, input logic [6:0] a,
                       input logic [3:0] e);
    tok_valid <= 1'b1;
    {tok_pid, tok_addr, tok_ep} <= {p, a, e};
    @(posedge clk);
    tok_valid <= 1'b0;
    {tok_pid, tok_addr, tok_ep} <= ~{p, a, e};
  endtask

  task automatic data(input logic ok, input logic d1, input logic [3:0] n);
    rx_done <= 1'b1;
    {rx_ok, rx_data1, rx_len} <= {ok, d1, n};
    @(posedge clk);
    rx_done <= 1'b0;
    {rx_ok, rx_data1, rx_len} <= ~{ok, d1, n};
  endtask

  task automatic strobe(input logic [4:0] m);
    {host_ack, host_timeout, bus_reset, sof_seen, resume_done} <= m;
    @(posedge clk);
    {host_ack, host_timeout, bus_reset, sof_seen, resume_done} <= 5'h0;
  endtask

  task automatic act(input int n);
    line_idle <= 1'b0;
    repeat (n) @(posedge clk);
    line_idle <= 1'b1;
  endtask

  // No pulse within the window reads as no answer at all
  task automatic answer(output uepc_hs_t k);
    k = HS_NONE;
    repeat (4) begin
      @(posedge clk);
      if (hs_valid === 1'b1) k = hs_kind;
    end
  endtask
endmodule

/* tb/tb.sv */
`timescale 1ns/1ns
module tb
  import uepc_pkg::*;
;
  localparam logic [31:0] A_BH = 32'h98, A_BL = 32'h9c, A_EV = 32'ha0;
  localparam logic [31:0] A_CT = 32'ha8, A_DA = 32'hac, A_T0 = 32'hb0;
  localparam logic [31:0] A_R0 = 32'hb4, A_T1 = 32'hb8, A_R1 = 32'hbc;
  typedef struct packed {
    logic [1:0] pid;
    logic [7:0] tx;
    logic [7:0] rx;
    logic [3:0] len;
    uepc_hs_t   k;
  } uepc_row_t;
  logic        clk, rst, hsel, hwrite, hready, hreadyout, hresp, hs_valid;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0]  htrans, tok_pid;
  logic [2:0]  hsize;
  logic [6:0]  tok_addr;
  logic [3:0]  tok_ep, rx_len, tx_len;
  logic        tok_valid, rx_done, rx_ok, rx_data1, host_ack, host_timeout;
  logic        bus_reset, sof_seen, resume_done, line_idle, tx_data1;
  logic        ev_good, ev_sleep, ev_wake, ev_busrst, ev_sof;
  logic        cpu_wake, pwr_down, resume_drive;
  logic [15:0] buf_addr;
  uepc_hs_t    hs_kind, k;
  int          fail_count, n_checks, cyc;
  uepc_row_t   rows [11] = '{
    '{TOK_IN, 8'h05, 8'h80, 4'h0, HS_NONE}, '{TOK_IN, 8'h15, 8'h80, 4'h0,
    HS_STALL}, '{TOK_IN, 8'h25, 8'h80, 4'h0, HS_NAK},
    '{TOK_IN, 8'h35, 8'h80, 4'h0, HS_DATA}, '{TOK_IN, 8'h73, 8'h80, 4'h0,
    HS_DATA}, '{TOK_OUT, 8'h00, 8'h80, 4'h4, HS_NONE},
    '{TOK_OUT, 8'h00, 8'h90, 4'h4, HS_STALL},
    '{TOK_OUT, 8'h00, 8'ha0, 4'h4, HS_NAK},
    '{TOK_OUT, 8'h00, 8'hb0, 4'h4, HS_ACK},
    '{TOK_OUT, 8'h80, 8'hb0, 4'h4, HS_STALL},
    '{TOK_OUT, 8'h80, 8'hb0, 4'h0, HS_ACK}};

  assign hready = hreadyout;

  uepc_endpoint_ctrl #(.IDLE_SLEEP_REQUEST_CYCLES(20)) i_uepc_endpoint_ctrl (.*);

  uepc_host_model u_host (.*);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      end_sim();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Waits on the bus ready only; the global cycle ceiling ends a hang
  task automatic ahb(input logic w, input logic [31:0] a, input logic [7:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0, d};
    do @(posedge clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask

  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    ahb(1'b1, a, d);
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    ahb(1'b0, a, 8'h00);
    chk(r, e);
  endtask

  task automatic xfer(input logic [1:0] p, input logic [3:0] ep,
                      input logic ok, input logic d1, input logic [3:0] n);
    u_host.token(p, 7'h00, ep);
    if (p != TOK_IN) u_host.data(ok, d1, n);
    u_host.answer(k);
  endtask

  initial begin
    {rst, hsize} = {1'b1, 3'b010};
    {hsel, hwrite, htrans, haddr, hwdata} = 68'h0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk(pwr_down, 1'b1);
    rd(A_R0, 32'h80);
    rd(A_T0, 32'h00);
    rd(A_CT, 32'h06);
    rd(A_DA, 32'h00);
    rd(A_EV, 32'h00);
    rd(32'h0, 32'h0);
    wr(A_R0, 8'h3f);
    rd(A_R0, 32'hb0);
    $display("test reset done");
    foreach (rows[i]) begin
      wr(A_EV, 8'h00);
      wr(A_T0, rows[i].tx);
      wr(A_R0, rows[i].rx);
      xfer(rows[i].pid, 4'h0, 1'b1, 1'b0, rows[i].len);
      chk(k, rows[i].k);
      if (k == HS_DATA) begin
        chk(tx_data1, rows[i].tx[6]);
        chk(tx_len, rows[i].tx[3:0]);
        u_host.strobe(5'b01000);
      end
    end
    $display("test table done");
    wr(A_EV, 8'h00);
    wr(A_T0, 8'h02);
    wr(A_T0, 8'h32);
    xfer(TOK_IN, 4'h0, 1'b1, 1'b0, 4'h0);
    chk(k, HS_DATA);
    u_host.strobe(5'b10000);
    rd(A_T0, 32'h62);
    rd(A_EV, 32'h20);
    wr(A_T0, 8'h32);
    rd(A_T0, 32'h32);
    xfer(TOK_IN, 4'h0, 1'b1, 1'b0, 4'h0);
    chk(k, HS_NAK);
    $display("test in done");
    wr(A_EV, 8'h00);
    wr(A_R0, 8'hb0);
    xfer(TOK_OUT, 4'h0, 1'b1, 1'b1, 4'h4);
    chk(k, HS_ACK);
    rd(A_R0, 32'hb0);
    rd(A_EV, 32'h00);
    xfer(TOK_OUT, 4'h0, 1'b0, 1'b0, 4'h4);
    chk(k, HS_NONE);
    xfer(TOK_OUT, 4'h0, 1'b1, 1'b0, 4'h4);
    rd(A_R0, 32'he0);
    $display("test out done");
    wr(A_EV, 8'h00);
    wr(A_T0, 8'h30);
    wr(A_R0, 8'hf0);
    xfer(TOK_SETUP, 4'h0, 1'b1, 1'b0, 4'h8);
    chk(k, HS_ACK);
    rd(A_T0, 32'h60);
    rd(A_R0, 32'he0);
    wr(A_EV, 8'h00);
    wr(A_BH, 8'hab);
    wr(A_BL, 8'hc0);
    wr(A_R1, 8'h35);
    xfer(TOK_SETUP, 4'h5, 1'b1, 1'b0, 4'h8);
    chk(k, HS_NONE);
    wr(A_R1, 8'hb5);
    xfer(TOK_SETUP, 4'h5, 1'b1, 1'b0, 4'h8);
    chk(k, HS_ACK);
    wr(A_EV, 8'h00);
    wr(A_T1, 8'h31);
    xfer(TOK_IN, 4'h5, 1'b1, 1'b0, 4'h0);
    chk(buf_addr, 16'habd0);
    u_host.strobe(5'b01000);
    $display("test setup done");
    wr(A_DA, 8'h12);
    xfer(TOK_OUT, 4'h0, 1'b1, 1'b0, 4'h2);
    chk(k, HS_NONE);
    u_host.strobe(5'b00100);
    rd(A_DA, 32'h00);
    rd(A_R1, 32'h00);
    rd(A_R0, 32'h80);
    rd(A_T1, 32'h00);
    chk(ev_busrst, 1'b1);
    wr(A_R0, 8'hb0);
    xfer(TOK_OUT, 4'h0, 1'b1, 1'b0, 4'h2);
    chk(k, HS_ACK);
    $display("test bus reset done");
    wr(A_EV, 8'h00);
    u_host.strobe(5'b00001);
    rd(A_EV, 32'h01);
    wr(A_EV, 8'h00);
    u_host.strobe(5'b00010);
    rd(A_EV, 32'h01);
    wr(A_EV, 8'h00);
    wr(A_CT, 8'h00);
    repeat (40) @(posedge clk);
    chk(pwr_down, 1'b0);
    rd(A_EV, 32'h80);
    wr(A_CT, 8'h0a);
    u_host.act(3);
    repeat (6) @(posedge clk);
    rd(A_EV, 32'h84);
    chk(cpu_wake, 1'b1);
    chk(resume_drive, 1'b1);
    rd(A_CT, 32'h08);
    $display("test suspend done");
    end_sim();
  end
endmodule
